// ---- rtl/mdsrd_reg_decode.sv ----
`timescale 1ns/100ps

module mdsrd_reg_decode (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe_n,
  input wire logic [9:0] microstep_position,
  input wire logic [9:0] stall_load_value,
  input wire logic [4:0] adapted_current_scale,
  input wire logic [7:0] status_flags,
  output logic step_dir_disable,
  output logic [1:0] response_select,
  output logic coil_a_polarity,
  output logic [7:0] coil_a_magnitude,
  output logic coil_b_polarity,
  output logic [7:0] coil_b_magnitude,
  output logic step_interpolation_enable,
  output logic double_edge_stepping,
  output logic [3:0] microstep_resolution,
  output logic [1:0] blank_time,
  output logic chopper_mode,
  output logic off_time_random,
  output logic [1:0] hysteresis_decrement,
  output logic [3:0] hysteresis_end,
  output logic [2:0] hysteresis_start,
  output logic [3:0] off_time,
  output logic minimum_current_select,
  output logic [1:0] current_decrement_speed,
  output logic [3:0] upper_load_threshold,
  output logic [1:0] current_increment_step,
  output logic [3:0] lower_load_threshold,
  output logic load_filter_enable,
  output logic [6:0] stall_threshold,
  output logic [4:0] current_scale,
  output logic test_mode,
  output logic [1:0] high_side_slope,
  output logic [1:0] low_side_slope,
  output logic ground_short_protect_off,
  output logic [1:0] ground_short_timer,
  output logic sense_range_select
);
  import mdsrd_pkg::*;

  // ****************************************************************
  // Serial link
  // ****************************************************************

  logic frame_done; // One-cycle pulse when a frame has closed.
  logic [FRAME_W-1:0] frame_word; // Command latched at frame close.
  logic [FRAME_W-1:0] resp_word; // Response offered to the next frame.

  // Pin sampling, shifting and daisy-chain pass-through live here.
  mdsrd_spi_link u_link (
    .sys_clk(sys_clk),
    .rst(rst),
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi),
    .resp_word(resp_word),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe_n(spi_sdo_oe_n),
    .frame_done(frame_done),
    .frame_word(frame_word)
  );

  // ****************************************************************
  // Target decode
  // ****************************************************************

  // Map the address bits of a frame onto its target register. The code 01 in
  // bits 19:18 names no register, so such a frame is dropped.
  function automatic mdsrd_target_t target_of(input logic [FRAME_W-1:0] word);
    mdsrd_target_t tgt;
    tgt = TGT_NONE;
    if (word[ADDR_LSB +: 2] == ADDR_DRIVER_CTRL) begin
      tgt = TGT_DRIVER;
    end else if (word[FRAME_W-1]) begin
      case (word[SUB_LSB +: 2])
        SUB_CHOPPER: tgt = TGT_CHOPPER;
        SUB_ADAPT: tgt = TGT_ADAPT;
        SUB_STALL: tgt = TGT_STALL;
        SUB_POWER: tgt = TGT_POWER;
        default: tgt = TGT_NONE;
      endcase
    end
    return tgt;
  endfunction

  mdsrd_target_t frame_target; // Target of the frame now closing.
  assign frame_target = target_of(frame_word);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************

  logic [FRAME_W-1:0] coil_current_or_step_setup; // Driver control word.
  logic [FRAME_W-1:0] chopper_setup; // Chopper word.
  logic [FRAME_W-1:0] load_adaptive_current_setup; // Adaptive current word.
  logic [FRAME_W-1:0] stall_detect_setup; // Stall detect word.
  logic [FRAME_W-1:0] power_stage_setup; // Power stage word.

  // At most one register takes the frame. Fixed bits are stored as sent;
  // the field decode below never reads them, so a careless host cannot
  // disturb a field through them.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      coil_current_or_step_setup <= REG_RESET;
      chopper_setup <= REG_RESET;
      load_adaptive_current_setup <= REG_RESET;
      stall_detect_setup <= REG_RESET;
      power_stage_setup <= REG_RESET;
    end else if (frame_done) begin
      case (frame_target)
        TGT_DRIVER: coil_current_or_step_setup <= frame_word;
        TGT_CHOPPER: chopper_setup <= frame_word;
        TGT_ADAPT: load_adaptive_current_setup <= frame_word;
        TGT_STALL: stall_detect_setup <= frame_word;
        TGT_POWER: power_stage_setup <= frame_word;
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Field decode
  // ****************************************************************

  // Plain fields are direct slices of their register flops.
  always_comb begin
    blank_time = chopper_setup[BLANK_LSB +: 2];
    chopper_mode = chopper_setup[CHOP_MODE_LSB];
    off_time_random = chopper_setup[RNDOFF_LSB];
    hysteresis_decrement = chopper_setup[HYST_DEC_LSB +: 2];
    hysteresis_end = chopper_setup[HYST_END_LSB +: 4];
    hysteresis_start = chopper_setup[HYST_START_LSB +: 3];
    off_time = chopper_setup[OFF_TIME_LSB +: 4];
    minimum_current_select = load_adaptive_current_setup[IMIN_LSB];
    current_decrement_speed = load_adaptive_current_setup[DECSPD_LSB +: 2];
    upper_load_threshold = load_adaptive_current_setup[UPTH_LSB +: 4];
    current_increment_step = load_adaptive_current_setup[INCSTEP_LSB +: 2];
    lower_load_threshold = load_adaptive_current_setup[LOWTH_LSB +: 4];
    load_filter_enable = stall_detect_setup[FILT_LSB];
    stall_threshold = stall_detect_setup[STHR_LSB +: 7];
    current_scale = stall_detect_setup[CSCALE_LSB +: 5];
    test_mode = power_stage_setup[TEST_LSB];
    high_side_slope = power_stage_setup[SLPH_LSB +: 2];
    low_side_slope = power_stage_setup[SLPL_LSB +: 2];
    ground_short_protect_off = power_stage_setup[S2GOFF_LSB];
    ground_short_timer = power_stage_setup[S2GTIM_LSB +: 2];
    sense_range_select = power_stage_setup[SENSE_RANGE_LSB];
    step_dir_disable = power_stage_setup[STEP_DIS_LSB];
    response_select = power_stage_setup[RESP_SEL_LSB +: 2];
  end

  // The driver-control word is read in the layout that the step-disable bit
  // picks now, so flipping that bit reinterprets the stored word at once.
  // Fields of the layout not in use read zero to keep stale values away.
  always_comb begin
    coil_a_polarity = 1'b0;
    coil_a_magnitude = 8'h00;
    coil_b_polarity = 1'b0;
    coil_b_magnitude = 8'h00;
    step_interpolation_enable = 1'b0;
    double_edge_stepping = 1'b0;
    microstep_resolution = 4'h0;
    if (step_dir_disable) begin
      coil_a_polarity = coil_current_or_step_setup[COIL_A_POL_LSB];
      coil_a_magnitude = coil_current_or_step_setup[COIL_A_MAG_LSB +: 8];
      coil_b_polarity = coil_current_or_step_setup[COIL_B_POL_LSB];
      coil_b_magnitude = coil_current_or_step_setup[COIL_B_MAG_LSB +: 8];
    end else begin
      step_interpolation_enable = coil_current_or_step_setup[INTERP_LSB];
      double_edge_stepping = coil_current_or_step_setup[DOUBLE_EDGE_LSB];
      microstep_resolution = coil_current_or_step_setup[USTEP_RES_LSB +: 4];
    end
  end

  // ****************************************************************
  // Response word
  // ****************************************************************

  logic [9:0] next_resp_hi; // Upper response field for the current select.

  // The unused select code 11 falls back to the position layout.
  always_comb begin
    case (response_select)
      RESP_SEL_POSITION: next_resp_hi = microstep_position;
      RESP_SEL_LOAD: next_resp_hi = stall_load_value;
      RESP_SEL_LOAD_CURRENT: begin
        next_resp_hi = {stall_load_value[9 -: LOAD_HALF_W], adapted_current_scale};
      end
      default: next_resp_hi = microstep_position;
    endcase
  end

  // Registered every cycle so the link sees a stable word when a frame opens;
  // the status is therefore one system clock old at that moment.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      resp_word <= REG_RESET;
    end else begin
      resp_word[FRAME_W-1:RESP_HI_LSB] <= next_resp_hi;
      resp_word[RESP_HI_LSB-1 -: 2] <= 2'h0;
      resp_word[7:0] <= status_flags;
    end
  end

endmodule

// ---- rtl/mdsrd_pkg.sv ----
package mdsrd_pkg;

  // ****************************************************************
  // Frame and register selection
  // ****************************************************************

  // Length of one command frame and of one response word.
  localparam int FRAME_W = 20;
  // Position of the two top address bits and of the sub-select pair.
  localparam int ADDR_LSB = 18;
  localparam int SUB_LSB = 17;
  // Top address code of the driver-control register.
  localparam logic [1:0] ADDR_DRIVER_CTRL = 2'h0;
  // Sub-select codes used when frame bit 19 is set.
  localparam logic [1:0] SUB_CHOPPER = 2'h0;
  localparam logic [1:0] SUB_ADAPT = 2'h1;
  localparam logic [1:0] SUB_STALL = 2'h2;
  localparam logic [1:0] SUB_POWER = 2'h3;
  // Every configuration register clears to this value.
  localparam logic [FRAME_W-1:0] REG_RESET = 20'h00000;

  // Target of a completed frame.
  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_DRIVER,
    TGT_CHOPPER,
    TGT_ADAPT,
    TGT_STALL,
    TGT_POWER
  } mdsrd_target_t;

  // ****************************************************************
  // Field positions (least significant bit of each field)
  // ****************************************************************

  // Driver control, coil current layout.
  localparam int COIL_A_POL_LSB = 17, COIL_A_MAG_LSB = 9, COIL_B_POL_LSB = 8, COIL_B_MAG_LSB = 0;
  // Driver control, step and direction layout.
  localparam int INTERP_LSB = 9, DOUBLE_EDGE_LSB = 8, USTEP_RES_LSB = 0;
  // Chopper setup.
  localparam int BLANK_LSB = 15, CHOP_MODE_LSB = 14, RNDOFF_LSB = 13, HYST_DEC_LSB = 11;
  localparam int HYST_END_LSB = 7, HYST_START_LSB = 4, OFF_TIME_LSB = 0;
  // Load adaptive current setup.
  localparam int IMIN_LSB = 15, DECSPD_LSB = 13, UPTH_LSB = 8, INCSTEP_LSB = 5, LOWTH_LSB = 0;
  // Stall detect setup.
  localparam int FILT_LSB = 16, STHR_LSB = 8, CSCALE_LSB = 0;
  // Power stage setup.
  localparam int TEST_LSB = 16, SLPH_LSB = 14, SLPL_LSB = 12, S2GOFF_LSB = 10, S2GTIM_LSB = 8;
  localparam int STEP_DIS_LSB = 7, SENSE_RANGE_LSB = 6, RESP_SEL_LSB = 4;

  // ****************************************************************
  // Response layout
  // ****************************************************************

  // Response-select codes.
  localparam logic [1:0] RESP_SEL_POSITION = 2'h0;
  localparam logic [1:0] RESP_SEL_LOAD = 2'h1;
  localparam logic [1:0] RESP_SEL_LOAD_CURRENT = 2'h2;
  // Upper response field starts at bit 10; status flags fill bits 7:0.
  localparam int RESP_HI_LSB = 10;
  // Width of the upper half of the stall load value shown with the current.
  localparam int LOAD_HALF_W = 5;

endpackage

// ---- rtl/mdsrd_spi_link.sv ----
`timescale 1ns/100ps

module mdsrd_spi_link (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  input wire logic [mdsrd_pkg::FRAME_W-1:0] resp_word,
  output logic spi_sdo,
  output logic spi_sdo_oe_n,
  output logic frame_done,
  output logic [mdsrd_pkg::FRAME_W-1:0] frame_word
);
  import mdsrd_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  logic sck_s1, sck_s2, sck_s3; // Bus clock; stage three only delays for edges.
  logic cs_n_s1, cs_n_s2, cs_n_s3; // Select, active low.
  logic sdi_s1, sdi_s2; // Serial data in.
  logic [FRAME_W-1:0] shift_reg; // Shared in/out shift register.

  // Two synchroniser flops per pin; edges are found between stages two and three only.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
      {cs_n_s1, cs_n_s2, cs_n_s3} <= 3'h7;
      {sdi_s1, sdi_s2} <= 2'h0;
    end else begin
      {sck_s1, sck_s2, sck_s3} <= {spi_sck, sck_s1, sck_s2};
      {cs_n_s1, cs_n_s2, cs_n_s3} <= {spi_cs_n, cs_n_s1, cs_n_s2};
      {sdi_s1, sdi_s2} <= {spi_sdi, sdi_s1};
    end
  end

  wire sck_rise = sck_s2 & ~sck_s3 & ~cs_n_s2; // Sampling edge inside a frame.
  wire sck_fall = ~sck_s2 & sck_s3 & ~cs_n_s2; // Launching edge inside a frame.
  wire cs_fall = ~cs_n_s2 & cs_n_s3; // Frame opens.
  wire cs_rise = cs_n_s2 & ~cs_n_s3; // Frame closes.

  // ****************************************************************
  // Shift register
  // ****************************************************************

  // The response is loaded at frame start and shifted out MSB first while the
  // command shifts in, so any surplus bits leave after twenty clocks.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shift_reg <= REG_RESET;
    end else if (cs_fall) begin
      shift_reg <= resp_word;
    end else if (sck_rise) begin
      shift_reg <= {shift_reg[FRAME_W-2:0], sdi_s2};
    end
  end

  // Output changes after falling bus-clock edges; the first bit is ready at
  // frame start, before the first rising edge.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      spi_sdo <= 1'b0;
    end else if (cs_fall) begin
      spi_sdo <= resp_word[FRAME_W-1];
    end else if (sck_fall) begin
      spi_sdo <= shift_reg[FRAME_W-1];
    end
  end

  // The output pin is driven only while the frame is open.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      spi_sdo_oe_n <= 1'b1;
    end else begin
      spi_sdo_oe_n <= cs_n_s2;
    end
  end

  // The last twenty bits are latched as the command when select rises.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_done <= 1'b0;
      frame_word <= REG_RESET;
    end else begin
      frame_done <= cs_rise;
      if (cs_rise) begin
        frame_word <= shift_reg;
      end
    end
  end

endmodule

// ---- sim/mdsrd_asserts.sv ----
`timescale 1ns/100ps
// ****
// Port checker
// ****
module mdsrd_asserts (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe_n,
  input wire logic [9:0] microstep_position,
  input wire logic step_dir_disable,
  input wire logic [1:0] response_select,
  input wire logic coil_a_polarity,
  input wire logic [7:0] coil_b_magnitude,
  input wire logic step_interpolation_enable,
  input wire logic [3:0] microstep_resolution,
  input wire logic [3:0] off_time,
  input wire logic [6:0] stall_threshold
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Reset itself is the cause here, so this one is not disabled by it.
  a_reset_clears: assert property (disable iff (1'b0) rst |=> !step_dir_disable &&
    response_select == 2'h0 && off_time == 4'h0 && stall_threshold == 7'h00)
    else $error("register not cleared");
  a_coil_zero: assert property (!step_dir_disable |-> !coil_a_polarity &&
    coil_b_magnitude == 8'h00) else $error("coil field live");
  a_step_zero: assert property (step_dir_disable |-> !step_interpolation_enable &&
    microstep_resolution == 4'h0) else $error("step field live");
  a_sdo_idle_off: assert property (spi_cs_n [*4] |-> spi_sdo_oe_n)
    else $error("sdo driven while idle");
  a_sdo_sel_on: assert property (!spi_cs_n [*5] |-> !spi_sdo_oe_n)
    else $error("sdo not driven");
  // Registers only move once a frame is closed, never mid-frame.
  a_cfg_hold: assert property (!spi_cs_n [*6] |=> $stable(off_time) &&
    $stable(stall_threshold) && $stable(step_dir_disable)) else $error("write mid frame");
  a_first_bit: assert property ($fell(spi_cs_n) && response_select == 2'h0 |->
    ##4 spi_sdo == microstep_position[9]) else $error("first bit wrong");
  a_sdo_after_fall: assert property (!spi_cs_n && $rose(spi_sck) |=>
    $stable(spi_sdo) [*2]) else $error("sdo moved after rise");
  c_coil_mode: cover property ($rose(step_dir_disable));
  c_sel_two: cover property (response_select == 2'h2);
  c_long_frame: cover property (!spi_cs_n [*8]);
endmodule

bind mdsrd_reg_decode mdsrd_asserts chk_u (.sys_clk, .rst, .spi_sck, .spi_cs_n, .spi_sdo,
  .spi_sdo_oe_n, .microstep_position, .step_dir_disable, .response_select, .coil_a_polarity,
  .coil_b_magnitude, .step_interpolation_enable, .microstep_resolution, .off_time,
  .stall_threshold);

// ---- sim/mdsrd_spi_master.sv ----
`timescale 1ns/100ps
// ****
// Host side serial master model
// ****
module mdsrd_spi_master (
  input wire logic sys_clk,
  input wire logic spi_sdo,
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_sdi
);
  // Clock parks low and select high between frames.
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end
  // The data line is released between frames, so it wanders instead of holding.
  always @(posedge sys_clk) begin
    if (spi_cs_n) begin
      spi_sdi <= ~spi_sdi;
    end
  end
  // One frame of n bits, MSB first, 320 ns per bit; q gathers the returned bits.
  task automatic xfer(input logic [39:0] d, input int n, output logic [39:0] q);
    q = 40'h0;
    @(posedge sys_clk);
    spi_cs_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    for (int i = n - 1; i >= 0; i--) begin
      spi_sdi <= d[i];
      repeat (4) @(posedge sys_clk);
      spi_sck <= 1'b1;
      repeat (2) @(posedge sys_clk);
      q = {q[38:0], spi_sdo};
      repeat (2) @(posedge sys_clk);
      spi_sck <= 1'b0;
    end
    repeat (2) @(posedge sys_clk);
    spi_cs_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule

// ---- sim/mdsrd_reg_decode_tb_top.sv ----
`timescale 1ns/100ps
// ****
// Bench top
// ****
module mdsrd_reg_decode_tb_top;
  import mdsrd_pkg::*;
  // Kinds 0 to 4 are register views, 5 the response, 6 the chained echo.
  typedef struct {int kind; logic [19:0] val;} mdsrd_note_t;
  localparam logic [19:0] PRE [6] = '{20'h0, 20'h80000, 20'ha0000, 20'hc0000, 20'he0000,
    20'h40000};
  localparam logic [19:0] MSK [6] = '{20'h3ffff, 20'h1ffff, 20'h0ef6f, 20'h17f1f, 20'h1f7f0,
    20'h1ffff};
  logic sys_clk, rst, spi_sck, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe_n;
  logic [9:0] microstep_position, stall_load_value;
  logic [4:0] adapted_current_scale, current_scale;
  logic [7:0] status_flags, coil_a_magnitude, coil_b_magnitude;
  logic step_dir_disable, coil_a_polarity, coil_b_polarity, step_interpolation_enable;
  logic double_edge_stepping, chopper_mode, off_time_random, minimum_current_select;
  logic load_filter_enable, test_mode, ground_short_protect_off, sense_range_select;
  logic [1:0] response_select, blank_time, hysteresis_decrement, current_decrement_speed;
  logic [1:0] current_increment_step, high_side_slope, low_side_slope, ground_short_timer;
  logic [3:0] microstep_resolution, hysteresis_end, off_time, upper_load_threshold;
  logic [3:0] lower_load_threshold;
  logic [2:0] hysteresis_start;
  logic [6:0] stall_threshold;
  logic [19:0] mdl [5]; // Expected stored words.
  logic [19:0] resp_got, echo_got;
  mdsrd_note_t notes [$];
  int bad_count = 0;
  int tests_run = 0;
  event done;

  mdsrd_reg_decode dut_u (.*);
  mdsrd_spi_master master_u (.sys_clk, .spi_sdo, .spi_sck, .spi_cs_n, .spi_sdi);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Rebuild each register word from the field outputs, fixed bits as zero.
  function automatic logic [19:0] view(int k);
    case (k)
      0: view = {2'h0, coil_a_polarity, coil_a_magnitude, coil_b_polarity, coil_b_magnitude} |
        {10'h0, step_interpolation_enable, double_edge_stepping, 4'h0, microstep_resolution};
      1: view = {3'h0, blank_time, chopper_mode, off_time_random, hysteresis_decrement,
        hysteresis_end, hysteresis_start, off_time};
      2: view = {4'h0, minimum_current_select, current_decrement_speed, 1'b0,
        upper_load_threshold, 1'b0, current_increment_step, 1'b0, lower_load_threshold};
      3: view = {3'h0, load_filter_enable, 1'b0, stall_threshold, 3'h0, current_scale};
      default: view = {3'h0, test_mode, high_side_slope, low_side_slope, 1'b0,
        ground_short_protect_off, ground_short_timer, step_dir_disable, sense_range_select,
        response_select, 4'h0};
    endcase
  endfunction

  // Note all five views; the driver word is seen through the current layout.
  task automatic views();
    for (int i = 0; i < 5; i++) begin
      notes.push_back('{i, i > 0 ? mdl[i] :
        mdl[0] & (mdl[4][7] ? 20'h3ffff : 20'h0030f)});
    end
    -> done;
  endtask

  // One write frame to target k (5 is the unused address), n bits long.
  task automatic wr(input int k, input logic [19:0] p, input int n);
    logic [39:0] q;
    logic [9:0] hi;
    @(posedge sys_clk);
    {microstep_position, stall_load_value, status_flags} <= 28'($urandom);
    adapted_current_scale <= 5'($urandom);
    @(posedge sys_clk);
    case (mdl[4][5:4])
      2'h1: hi = stall_load_value;
      2'h2: hi = {stall_load_value[9:5], adapted_current_scale};
      default: hi = microstep_position;
    endcase
    master_u.xfer({p ^ 20'h5a5a5, PRE[k] | (p & MSK[k])}, n, q);
    resp_got = q[n-1 -: 20];
    echo_got = q[19:0];
    notes.push_back('{5, {hi, 2'h0, status_flags}});
    if (n > 20) notes.push_back('{6, p ^ 20'h5a5a5});
    if (k < 5) mdl[k] = p & MSK[k];
    views();
  endtask

  // Takes each note when its frame completes and compares it with the outputs.
  initial begin
    mdsrd_note_t n;
    logic [19:0] got;
    forever begin
      @(done);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        got = n.kind == 5 ? resp_got : (n.kind == 6 ? echo_got : view(n.kind));
        tests_run++;
        if (got !== n.val) begin
          bad_count++;
          $display("unexpected at %0t: kind %0d got %h want %h", $time, n.kind, got, n.val);
        end
      end
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run is near 426 us; a hang is cut at 2 ms.
  initial begin
    #2000000;
    bad_count++;
    finish_test();
  end

  initial begin
    void'($urandom(32'hc9ae));
    rst = 1'b1;
    {microstep_position, stall_load_value, adapted_current_scale, status_flags} = 33'h0;
    foreach (mdl[i]) mdl[i] = 20'h0;
    for (int pass = 0; pass < 2; pass++) begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      views();
      wr(4, 20'h00080, 20);
      repeat (3) wr(0, 20'($urandom), 20);
      wr(4, 20'h00000, 20);
      repeat (3) wr(0, 20'($urandom), 20);
      for (int r = 0; r < 4; r++) wr(4, (20'($urandom) & 20'hfffcf) | 20'(r << 4), 20);
      for (int k = 1; k < 6; k++) begin
        repeat (3) wr(k, 20'($urandom), k == 3 ? 40 : 20);
      end
      @(posedge sys_clk);
      rst <= 1'b1;
      foreach (mdl[i]) mdl[i] = 20'h0;
    end
    finish_test();
  end
endmodule
